// *** power_mode_pkg.sv ***
// Summary of operation
// - Start in active mode after power-up
// - Active: measure, estimate, FETs only when safe
// - Sleep halts measurement, keeps all registers
// - Sleep drops FET drive, hash unavailable
// - Two sleep causes, each with enable
// - Charger or charge current blocks sleep
// - Wake on charger or rising line
// - Bus-low sleep needs enable, lines low
// - Bus-low sleep: zero current, no counting
// - Undervoltage sleep needs enable bit set
// - Undervoltage sleep needs static lines timeout
// - Undervoltage sleep wakes on any change
// - Switch wake on I/O or data pin
// - Zero qualification delay within window
// - Weak pulldown on data pin, only while active
// - Switch wake pulls pin high, falling wakes
// - Debounce I/O wake input 100ms
// - No switch wake after undervoltage sleep
package power_mode_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam int BUS_LOW_SLEEP_EN_BIT = 0;
  localparam int UV_SLEEP_EN_BIT = 1;
  localparam int GPIO_WAKE_EN_BIT = 2;
  localparam int DATA_WAKE_EN_BIT = 3;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam longint unsigned CLK_HZ = 200_000_000;
  localparam longint unsigned SLEEP_TIMEOUT_MS = 2000;
  localparam longint unsigned ACT_WINDOW_MS = 100;
  localparam longint unsigned DEBOUNCE_MS = 100;
  // Least time rounds up, window and typical debounce round down
  localparam longint unsigned SLEEP_CYC = (SLEEP_TIMEOUT_MS * CLK_HZ + 999) / 1000;
  localparam longint unsigned WINDOW_CYC = ACT_WINDOW_MS * CLK_HZ / 1000;
  localparam longint unsigned DEBOUNCE_CYC = DEBOUNCE_MS * CLK_HZ / 1000;

  // Power modes
  typedef enum logic [1:0] {
    ST_ACTIVE,
    ST_SLEEP_BUS,
    ST_SLEEP_UV
  } pm_state_e;

endpackage : power_mode_pkg

// *** pin_sync.sv ***
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int N = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Pins in and clean levels out
  input wire logic [N-1:0] async_in,
  output logic [N-1:0] stable_q
);

  // ----------------------------------------
  // Three-stage capture per bit
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_bit
      logic s1_q;
      logic s2_q;
      logic s3_q;
      // Level accepted only once stages two and three agree
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
          stable_q[i] <= 1'b0;
        end else begin
          s1_q <= async_in[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) begin
            stable_q[i] <= s3_q;
          end
        end
      end
    end
  endgenerate

endmodule : pin_sync
`default_nettype wire

// *** span_timer.sv ***
`timescale 1ns/10ps
`default_nettype none
module span_timer #(
  parameter int W = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Control
  input wire logic restart,
  input wire logic [W-1:0] limit,
  output logic done
);

  logic [W-1:0] cnt_q;

  // Saturating count, so done stays up until the next restart
  assign done = (cnt_q >= limit);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= '0;
    end else if (restart) begin
      cnt_q <= '0;
    end else if (!done) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

endmodule : span_timer
`default_nettype wire

// *** power_mode_ctrl.sv ***
`timescale 1ns/10ps
`default_nettype none
module power_mode_ctrl
  import power_mode_pkg::*;
#(
  parameter logic [31:0] SLEEP_TIMEOUT_CYC = 32'(SLEEP_CYC),
  parameter logic [31:0] ACT_WINDOW_CYC = 32'(WINDOW_CYC),
  parameter logic [31:0] DEBOUNCE_WAKE_CYC = 32'(DEBOUNCE_CYC)
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // Register port
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  // Communication and wake pins
  input wire logic DATA_PIN_IN,
  input wire logic CLOCK_PIN_IN,
  input wire logic PROGRAMMABLE_IO_PIN_IN,
  // Pin bias controls
  output logic DATA_PULLDOWN_EN,
  output logic DATA_PULLUP_EN,
  output logic PROGRAMMABLE_IO_PULLUP_EN,
  // Analog detectors
  input wire logic CHARGER_DETECT,
  input wire logic CHARGE_CURRENT_DETECT,
  input wire logic UNDERVOLTAGE_DETECT,
  input wire logic CHARGE_PATH_SAFE,
  input wire logic DISCHARGE_PATH_SAFE,
  // Function gating
  output logic ACTIVE_MODE,
  output logic MEASURE_ENABLE,
  output logic COULOMB_ENABLE,
  output logic CURRENT_FORCE_ZERO,
  output logic CHARGE_FET_CONTROL,
  output logic DISCHARGE_FET_CONTROL,
  output logic HASH_ENABLE,
  output logic QUAL_DELAY_BYPASS
);

  // ----------------------------------------
  // Input capture
  // ----------------------------------------
  logic [7:0] pins_s;
  logic data_s;
  logic clock_s;
  logic pio_s;
  logic charger_s;
  logic chg_cur_s;
  logic uv_s;
  logic chg_safe_s;
  logic dis_safe_s;

  // Detectors are asynchronous comparators, so they are captured too
  pin_sync #(.N(8)) u_sync (
    .clk(CLK),
    .resetn(RESETN),
    .async_in({DISCHARGE_PATH_SAFE, CHARGE_PATH_SAFE, UNDERVOLTAGE_DETECT,
               CHARGE_CURRENT_DETECT, CHARGER_DETECT, PROGRAMMABLE_IO_PIN_IN,
               CLOCK_PIN_IN, DATA_PIN_IN}),
    .stable_q(pins_s)
  );

  assign data_s = pins_s[0];
  assign clock_s = pins_s[1];
  assign pio_s = pins_s[2];
  assign charger_s = pins_s[3];
  assign chg_cur_s = pins_s[4];
  assign uv_s = pins_s[5];
  assign chg_safe_s = pins_s[6];
  assign dis_safe_s = pins_s[7];

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  pm_state_e state_q;
  pm_state_e state_d;
  logic [3:0] ctrl_q;
  logic [7:0] rdata_q;
  logic [1:0] lines_q;
  logic data_prev_q;
  logic out_active_q;
  logic out_coulomb_q;
  logic out_zero_q;
  logic out_chg_fet_q;
  logic out_dis_fet_q;
  logic out_bypass_q;
  logic out_data_pu_q;
  logic out_pio_pu_q;

  // ----------------------------------------
  // Line activity
  // ----------------------------------------
  logic [1:0] lines_now;
  logic line_change;
  logic line_rise;
  logic data_fall;
  logic lines_low;
  logic data_pu_on;
  logic pio_pu_on;

  assign lines_now = {clock_s, data_s};
  assign line_change = |(lines_now ^ lines_q);
  // Rising data is ignored while our own pullup lifts the line
  assign line_rise = (clock_s & ~lines_q[1]) | (data_s & ~lines_q[0] & ~data_pu_on);
  assign data_fall = ~data_s & data_prev_q;
  assign lines_low = (lines_now == 2'b00) & (lines_q == 2'b00); // Low now and one clock cycle ago

  // ----------------------------------------
  // Timers
  // ----------------------------------------
  logic idle_done;
  logic window_done;
  logic debounce_done;

  // Idle span restarts on any line edge and is held while asleep
  span_timer #(.W(32)) u_idle (
    .clk(CLK),
    .resetn(RESETN),
    .restart(line_change | (state_q != ST_ACTIVE)),
    .limit(SLEEP_TIMEOUT_CYC),
    .done(idle_done)
  );

  // Window starts at reset and at each return to active
  span_timer #(.W(32)) u_window (
    .clk(CLK),
    .resetn(RESETN),
    .restart(state_q != ST_ACTIVE),
    .limit(ACT_WINDOW_CYC),
    .done(window_done)
  );

  // I/O pin must stay low for the debounce span to count as a press
  span_timer #(.W(32)) u_debounce (
    .clk(CLK),
    .resetn(RESETN),
    .restart(pio_s | ~pio_pu_on),
    .limit(DEBOUNCE_WAKE_CYC),
    .done(debounce_done)
  );

  // ----------------------------------------
  // Sleep entry and wake decisions
  // ----------------------------------------
  logic sleep_block;
  logic bus_low_go;
  logic uv_go;
  logic bus_wake;
  logic uv_wake;

  // Switch wake exists only after bus-low sleep
  assign data_pu_on = (state_q == ST_SLEEP_BUS) & ctrl_q[DATA_WAKE_EN_BIT];
  assign pio_pu_on = (state_q == ST_SLEEP_BUS) & ctrl_q[GPIO_WAKE_EN_BIT];
  assign sleep_block = charger_s | chg_cur_s;
  // Each cause has its own enable
  assign bus_low_go = ctrl_q[BUS_LOW_SLEEP_EN_BIT] & lines_low & idle_done;
  assign uv_go = ctrl_q[UV_SLEEP_EN_BIT] & uv_s & idle_done & ~line_change;
  // Switch wake restores the FETs by returning to active
  assign bus_wake = charger_s | line_rise | (data_pu_on & data_fall)
                  | (pio_pu_on & debounce_done);
  assign uv_wake = charger_s | line_change;

  // Next mode; undervoltage wins when both causes are ready
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_ACTIVE: begin
        if (!sleep_block && uv_go) begin
          state_d = ST_SLEEP_UV;
        end else if (!sleep_block && bus_low_go) begin
          state_d = ST_SLEEP_BUS;
        end
      end
      ST_SLEEP_BUS: begin
        if (bus_wake) begin
          state_d = ST_ACTIVE;
        end
      end
      ST_SLEEP_UV: begin
        if (uv_wake) begin
          state_d = ST_ACTIVE;
        end
      end
    endcase
  end

  // ----------------------------------------
  // Register port decode
  // ----------------------------------------
  logic ctrl_wr;
  logic [7:0] status_word;
  logic [7:0] read_mux;

  assign ctrl_wr = REG_WR & (REG_ADDR == CTRL_OFS);
  assign status_word = {sleep_block, pio_s, clock_s, data_s, out_bypass_q,
                        state_q == ST_SLEEP_UV, state_q == ST_SLEEP_BUS,
                        state_q == ST_ACTIVE};
  assign read_mux = (REG_ADDR == CTRL_OFS) ? {4'h0, ctrl_q} :
                    (REG_ADDR == STATUS_OFS) ? status_word : 8'h00;

  // Control and read data; sleep leaves every register as it was
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ctrl_q <= CTRL_RST;
      rdata_q <= 8'h00;
    end else begin
      if (ctrl_wr) begin
        ctrl_q <= REG_WDATA[3:0];
      end
      rdata_q <= REG_RD ? read_mux : 8'h00;
    end
  end

  // ----------------------------------------
  // Mode and line history
  // ----------------------------------------
  // Reset lands in active mode with the window running
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_q <= ST_ACTIVE;
      lines_q <= 2'b00;
      data_prev_q <= 1'b0;
    end else begin
      state_q <= state_d;
      lines_q <= lines_now;
      data_prev_q <= data_s;
    end
  end

  // ----------------------------------------
  // Registered outputs, computed from next mode
  // ----------------------------------------
  logic active_d;

  assign active_d = (state_d == ST_ACTIVE);

  // FETs stay off at reset until the protector judges them safe
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      out_active_q <= 1'b1;
      out_coulomb_q <= 1'b1;
      out_zero_q <= 1'b0;
      out_chg_fet_q <= 1'b0;
      out_dis_fet_q <= 1'b0;
      out_bypass_q <= 1'b1;
      out_data_pu_q <= 1'b0;
      out_pio_pu_q <= 1'b0;
    end else begin
      out_active_q <= active_d;
      out_coulomb_q <= active_d;
      out_zero_q <= (state_d == ST_SLEEP_BUS);
      out_chg_fet_q <= active_d & chg_safe_s;
      out_dis_fet_q <= active_d & dis_safe_s;
      out_bypass_q <= active_d & (~window_done | (state_q != ST_ACTIVE));
      out_data_pu_q <= (state_d == ST_SLEEP_BUS) & ctrl_q[DATA_WAKE_EN_BIT];
      out_pio_pu_q <= (state_d == ST_SLEEP_BUS) & ctrl_q[GPIO_WAKE_EN_BIT];
    end
  end

  assign REG_RDATA = rdata_q;
  assign ACTIVE_MODE = out_active_q;
  assign MEASURE_ENABLE = out_active_q;
  assign HASH_ENABLE = out_active_q;
  assign COULOMB_ENABLE = out_coulomb_q;
  assign CURRENT_FORCE_ZERO = out_zero_q;
  assign CHARGE_FET_CONTROL = out_chg_fet_q;
  assign DISCHARGE_FET_CONTROL = out_dis_fet_q;
  assign QUAL_DELAY_BYPASS = out_bypass_q;
  // Weak pulldown while awake so a detached pack reads as bus-low
  assign DATA_PULLDOWN_EN = out_active_q;
  assign DATA_PULLUP_EN = out_data_pu_q;
  assign PROGRAMMABLE_IO_PULLUP_EN = out_pio_pu_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);

  sequence s_enter_active;
    (state_q != ST_ACTIVE) ##1 (state_q == ST_ACTIVE);
  endsequence

  sequence s_enter_bus_sleep;
    (state_q == ST_ACTIVE) ##1 (state_q == ST_SLEEP_BUS);
  endsequence

  sequence s_enter_uv_sleep;
    (state_q == ST_ACTIVE) ##1 (state_q == ST_SLEEP_UV);
  endsequence

  property p_fet_needs_safe;
    CHARGE_FET_CONTROL |-> ($past(chg_safe_s) && ACTIVE_MODE);
  endproperty
  a_fet_needs_safe: assert property (p_fet_needs_safe)
    else $error("charge FET on without safe condition");

  property p_sleep_gates_all;
    (state_q != ST_ACTIVE) |-> (!MEASURE_ENABLE && !HASH_ENABLE
      && !CHARGE_FET_CONTROL && !DISCHARGE_FET_CONTROL);
  endproperty
  a_sleep_gates_all: assert property (p_sleep_gates_all)
    else $error("function left enabled during sleep");

  property p_block_sleep;
    (state_q == ST_ACTIVE && sleep_block) |=> (state_q == ST_ACTIVE);
  endproperty
  a_block_sleep: assert property (p_block_sleep)
    else $error("sleep entered while charger or charge current seen");

  property p_bus_entry_cause;
    s_enter_bus_sleep |-> ($past(ctrl_q[BUS_LOW_SLEEP_EN_BIT])
      && $past(lines_now) == 2'b00 && $past(idle_done));
  endproperty
  a_bus_entry_cause: assert property (p_bus_entry_cause)
    else $error("bus-low sleep without enable or idle low lines");

  property p_bus_sleep_counting;
    (state_q == ST_SLEEP_BUS) |-> (CURRENT_FORCE_ZERO && !COULOMB_ENABLE);
  endproperty
  a_bus_sleep_counting: assert property (p_bus_sleep_counting)
    else $error("coulomb counting during bus-low sleep");

  property p_uv_entry_cause;
    s_enter_uv_sleep |-> ($past(ctrl_q[UV_SLEEP_EN_BIT]) && $past(uv_s)
      && $past(idle_done) && !$past(line_change));
  endproperty
  a_uv_entry_cause: assert property (p_uv_entry_cause)
    else $error("undervoltage sleep without enable or static bus");

  property p_uv_wake_change;
    (state_q == ST_SLEEP_UV && line_change) |=> (state_q == ST_ACTIVE);
  endproperty
  a_uv_wake_change: assert property (p_uv_wake_change)
    else $error("no wake on line change in undervoltage sleep");

  property p_charger_wake;
    (state_q != ST_ACTIVE && charger_s) |=> (state_q == ST_ACTIVE) ##1 ACTIVE_MODE;
  endproperty
  a_charger_wake: assert property (p_charger_wake)
    else $error("charger did not wake the device");

  property p_window_bypass;
    s_enter_active |-> QUAL_DELAY_BYPASS [*8];
  endproperty
  a_window_bypass: assert property (p_window_bypass)
    else $error("qualification delay not bypassed after wake");

  property p_uv_no_switch;
    (state_q == ST_SLEEP_UV) |-> (!DATA_PULLUP_EN && !PROGRAMMABLE_IO_PULLUP_EN);
  endproperty
  a_uv_no_switch: assert property (p_uv_no_switch)
    else $error("switch wake armed in undervoltage sleep");

  property p_pulldown_awake;
    ACTIVE_MODE |-> (DATA_PULLDOWN_EN && !DATA_PULLUP_EN);
  endproperty
  a_pulldown_awake: assert property (p_pulldown_awake)
    else $error("data pin bias wrong in active mode");

endmodule : power_mode_ctrl
`default_nettype wire

// *** host_link_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module host_link_model (
  // Clock
  input wire logic clk,
  // Host and wake switch commands
  input wire logic data_release,
  input wire logic host_data,
  input wire logic host_clock,
  input wire logic switch_closed,
  // Bias controls from the device
  input wire logic data_pullup_en,
  input wire logic data_pulldown_en,
  input wire logic io_pullup_en,
  // Resolved line levels
  output logic data_line,
  output logic clock_line,
  output logic io_line
);
  // ----------------------------------------
  // Line resolution
  // ----------------------------------------
  logic float_q = 1'b0;

  // An unbiased pin wanders, so it never looks like a steady level
  always_ff @(posedge clk) begin
    float_q <= ~float_q;
  end

  // Released data follows the device bias only
  assign data_line = !data_release ? host_data : data_pullup_en ? 1'b1 :
                     data_pulldown_en ? 1'b0 : float_q;
  assign clock_line = host_clock;
  // A closed dry contact grounds the pin
  assign io_line = switch_closed ? 1'b0 : io_pullup_en ? 1'b1 : float_q;
endmodule : host_link_model
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/10ps
`default_nettype none
module testbench
  import power_mode_pkg::*;
;
  // ----------------------------------------
  // Stimulus, wiring and helpers
  // ----------------------------------------
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic data_release = 1'b0;
  logic host_data = 1'b1;
  logic host_clock = 1'b1;
  logic switch_closed = 1'b0;
  logic charger = 1'b0;
  logic chg_current = 1'b0;
  logic undervolt = 1'b0;
  logic safe_chg = 1'b1;
  logic safe_dis = 1'b1;
  logic [7:0] rdata;
  logic data_line, clock_line, io_line, pd_en, pu_en, io_pu_en;
  logic active, measure, coulomb, force_zero, chg_fet, dis_fet, hash_en, qual_bypass;
  int errors = 0;
  int checks = 0;

  // Short counts keep the run brief
  power_mode_ctrl #(.SLEEP_TIMEOUT_CYC(32'd64), .ACT_WINDOW_CYC(32'd32),
    .DEBOUNCE_WAKE_CYC(32'd16)) dut (.CLK(clk), .RESETN(resetn), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(rdata),
    .DATA_PIN_IN(data_line), .CLOCK_PIN_IN(clock_line), .PROGRAMMABLE_IO_PIN_IN(io_line),
    .DATA_PULLDOWN_EN(pd_en), .DATA_PULLUP_EN(pu_en), .PROGRAMMABLE_IO_PULLUP_EN(io_pu_en),
    .CHARGER_DETECT(charger), .CHARGE_CURRENT_DETECT(chg_current),
    .UNDERVOLTAGE_DETECT(undervolt), .CHARGE_PATH_SAFE(safe_chg),
    .DISCHARGE_PATH_SAFE(safe_dis), .ACTIVE_MODE(active), .MEASURE_ENABLE(measure),
    .COULOMB_ENABLE(coulomb), .CURRENT_FORCE_ZERO(force_zero),
    .CHARGE_FET_CONTROL(chg_fet), .DISCHARGE_FET_CONTROL(dis_fet), .HASH_ENABLE(hash_en),
    .QUAL_DELAY_BYPASS(qual_bypass));

  host_link_model host (.clk(clk), .data_release(data_release), .host_data(host_data),
    .host_clock(host_clock), .switch_closed(switch_closed), .data_pullup_en(pu_en),
    .data_pulldown_en(pd_en), .io_pullup_en(io_pu_en), .data_line(data_line),
    .clock_line(clock_line), .io_line(io_line));

  // Free-running 200 MHz clock
  initial begin
    forever #2.5 clk = ~clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cycles

  task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= addr;
    reg_wdata <= data;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  // Read data stands only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] addr, output logic [7:0] data);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= addr;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    data = rdata;
  endtask : reg_read

  task automatic set_lines(input logic d, input logic c);
    @(posedge clk);
    host_data <= d;
    host_clock <= c;
  endtask : set_lines

  task automatic wait_mode(input logic exp, input int limit);
    int n;
    n = 0;
    while (active !== exp && n < limit) begin
      cycles(1);
      n++;
    end
    check(active, exp);
  endtask : wait_mode

  // Host holds both lines low only when it wants the pack asleep
  task automatic bus_sleep(input logic [7:0] ctrl);
    reg_write(CTRL_OFS, ctrl);
    set_lines(1'b0, 1'b0);
    wait_mode(1'b0, 150);
  endtask : bus_sleep

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_reset;
    logic [7:0] v;
    #1;
    check(active, 1'b1);
    check({measure, coulomb, hash_en, force_zero}, 8'h0e);
    check(pd_en, 1'b1);
    reg_read(CTRL_OFS, v);
    check(v, CTRL_RST);
    reg_write(STATUS_OFS, 8'hff);
    reg_read(STATUS_OFS, v);
    check(v[2:0], 3'b001);
    reg_read(8'h08, v);
    check(v, 8'h00);
    check({chg_fet, dis_fet}, 2'b11);
    check(qual_bypass, 1'b1);
    @(posedge clk);
    safe_chg <= 1'b0;
    cycles(8);
    check({chg_fet, dis_fet}, 2'b01);
    @(posedge clk);
    safe_chg <= 1'b1;
    cycles(30);
    check(qual_bypass, 1'b0);
    $display("test reset done");
  endtask : test_reset

  // Neither cause enabled: low or undervoltage must not sleep
  task automatic test_no_enable;
    @(posedge clk);
    undervolt <= 1'b1;
    set_lines(1'b0, 1'b0);
    cycles(150);
    check(active, 1'b1);
    @(posedge clk);
    undervolt <= 1'b0;
    set_lines(1'b1, 1'b1);
    $display("test no_enable done");
  endtask : test_no_enable

  task automatic test_bus_sleep;
    logic [7:0] v;
    reg_write(CTRL_OFS, 8'h01);
    set_lines(1'b0, 1'b0);
    cycles(50);
    set_lines(1'b0, 1'b1);
    cycles(4);
    set_lines(1'b0, 1'b0);
    cycles(50);
    check(active, 1'b1);
    wait_mode(1'b0, 100);
    check({measure, hash_en, chg_fet, dis_fet}, 8'h00);
    check({coulomb, force_zero}, 2'b01);
    reg_read(CTRL_OFS, v);
    check(v, 8'h01);
    set_lines(1'b0, 1'b1);
    wait_mode(1'b1, 20);
    check({qual_bypass, force_zero}, 2'b10);
    for (int k = 0; k < 2; k++) begin
      bus_sleep(8'h01);
      @(posedge clk);
      if (k == 0) host_data <= 1'b1;
      else charger <= 1'b1;
      wait_mode(1'b1, 20);
      @(posedge clk);
      charger <= 1'b0;
      host_data <= 1'b1;
      host_clock <= 1'b1;
    end
    $display("test bus_sleep done");
  endtask : test_bus_sleep

  // Charger or charge current holds the device awake
  task automatic test_block;
    logic [7:0] v;
    reg_write(CTRL_OFS, 8'h01);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      charger <= (k == 0);
      chg_current <= (k == 1);
      set_lines(1'b0, 1'b0);
      cycles(150);
      check(active, 1'b1);
      reg_read(STATUS_OFS, v);
      check(v[7], 1'b1);
      // Lines rise first, else the expired idle span sleeps unblocked
      set_lines(1'b1, 1'b1);
      @(posedge clk);
      charger <= 1'b0;
      chg_current <= 1'b0;
    end
    $display("test block done");
  endtask : test_block

  task automatic test_uv;
    logic [7:0] v;
    reg_write(CTRL_OFS, 8'h0e);
    @(posedge clk);
    undervolt <= 1'b1;
    wait_mode(1'b0, 150);
    check({force_zero, pu_en, io_pu_en}, 3'b000);
    reg_read(STATUS_OFS, v);
    check(v[2:0], 3'b100);
    set_lines(1'b0, 1'b1);
    wait_mode(1'b1, 20);
    @(posedge clk);
    undervolt <= 1'b0;
    set_lines(1'b1, 1'b1);
    $display("test uv done");
  endtask : test_uv

  // Dry contact wake on the io pin, then on the data line
  task automatic test_switch;
    bus_sleep(8'h05);
    check(io_pu_en, 1'b1);
    @(posedge clk);
    switch_closed <= 1'b1;
    cycles(8);
    @(posedge clk);
    switch_closed <= 1'b0;
    cycles(30);
    check(active, 1'b0);
    @(posedge clk);
    switch_closed <= 1'b1;
    wait_mode(1'b1, 40);
    @(posedge clk);
    switch_closed <= 1'b0;
    bus_sleep(8'h09);
    check(pu_en, 1'b1);
    @(posedge clk);
    data_release <= 1'b1;
    cycles(20);
    check(active, 1'b0);
    @(posedge clk);
    data_release <= 1'b0;
    wait_mode(1'b1, 20);
    set_lines(1'b1, 1'b1);
    $display("test switch done");
  endtask : test_switch

  task automatic stop_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test

  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    test_reset;
    test_no_enable;
    test_bus_sleep;
    test_block;
    test_uv;
    test_switch;
    stop_test;
  end

  // Whole run needs under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    stop_test;
  end
endmodule : testbench
`default_nettype wire
